//--- verilog/vdcr_pkg.sv
`default_nettype none
package vdcr_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFF_LUMA_PROC_TWO  = 8'h08;
	localparam logic [7:0] OFF_BRIGHTNESS     = 8'h09;
	localparam logic [7:0] OFF_SATURATION     = 8'h0a;
	localparam logic [7:0] OFF_HUE            = 8'h0b;
	localparam logic [7:0] OFF_CONTRAST       = 8'h0c;
	localparam logic [7:0] OFF_OUTPUT_FORMAT  = 8'h0d;
	localparam logic [7:0] OFF_LUMA_TRAP      = 8'h0e;
	localparam logic [7:0] OFF_SHARED_PIN     = 8'h0f;
	localparam logic [7:0] OFF_CROP_START_HI  = 8'h11;
	localparam logic [7:0] OFF_CROP_START_LO  = 8'h12;
	localparam logic [7:0] OFF_CROP_STOP_HI   = 8'h13;
	localparam logic [7:0] OFF_CROP_STOP_LO   = 8'h14;
	localparam logic [7:0] OFF_GENLOCK        = 8'h15;
	localparam logic [7:0] OFF_VBLANK_START   = 8'h18;
	localparam logic [7:0] OFF_VBLANK_STOP    = 8'h19;
	localparam logic [7:0] OFF_CHROMA_ONE     = 8'h1a;
	localparam int         REG_SLOTS          = 32;
	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int LUMA_FILTER_BIT   = 6;
	localparam int PEAK_LSB          = 2;
	localparam int RANGE_BIT         = 6;
	localparam int CHROMA_FMT_BIT    = 5;
	localparam int BYPASS_LSB        = 3;
	localparam int PIN23_LOCK_BIT    = 6;
	localparam int VSYNC_LOCK_BIT    = 5;
	localparam int PALFLAG_LOCK_BIT  = 4;
	localparam int PIN23_SEL_BIT     = 3;
	localparam int PIN24_SEL_BIT     = 2;
	localparam int PIN27_SEL_BIT     = 1;
	localparam int CLOCK_SEL_BIT     = 0;
	localparam int ACTIVE_VIDEO_FLAG_SUPPRESS_BIT = 2;
	localparam int OSC_LSB_BIT       = 2;
	localparam int RTC_SEL_BIT       = 0;
	localparam int PLL_RESET_BIT     = 4;
	localparam int ADAPTIVE_BIT      = 3;
	localparam int COMB_BIT          = 2;
	////////////////////////////////////////////////////////////////////////////////
	// codes and limits
	localparam logic [1:0] BYPASS_DECIM     = 2'b01;
	localparam logic [1:0] BYPASS_RAW       = 2'b10;
	localparam logic [2:0] FORMAT_DISCRETE  = 3'b000;
	localparam logic [2:0] FORMAT_EMBEDDED  = 3'b111;
	localparam logic [7:0] LUMA_MIN_STD     = 8'h10;
	localparam logic [7:0] LUMA_MAX_STD     = 8'heb;
	localparam logic [7:0] CHROMA_MAX_STD   = 8'hf0;
	localparam logic [7:0] CODE_MIN_EXT     = 8'h01;
	localparam logic [7:0] CODE_MAX_EXT     = 8'hfe;
	localparam logic [7:0] CHROMA_ZERO      = 8'h80;
	localparam logic [7:0] EARLIEST_CODE    = 8'hff;
	localparam logic [7:0] EARLY_MAX        = 8'h80;
	localparam logic [6:0] DEV_ADDR         = 7'h5d;
	localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
	localparam logic [3:0] LAST_BIT         = 4'h7;
	////////////////////////////////////////////////////////////////////////////////
	// serial slave states
	typedef enum logic [3:0] {
		I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_SUBADDR, I2C_ACK_SUB,
		I2C_WDATA, I2C_ACK_WR, I2C_RDATA, I2C_RACK
	} vdcr_i2c_state_t;
	////////////////////////////////////////////////////////////////////////////////
	// per-register writable bits; unmapped offsets hold nothing
	function automatic logic [7:0] vdcrWriteMask(input logic [7:0] a);
		if (a == OFF_LUMA_PROC_TWO) vdcrWriteMask = 8'h4c;
		else if (a == OFF_BRIGHTNESS || a == OFF_SATURATION || a == OFF_HUE) vdcrWriteMask = 8'hff;
		else if (a == OFF_CONTRAST || a == OFF_CROP_START_HI || a == OFF_CROP_STOP_HI) vdcrWriteMask = 8'hff;
		else if (a == OFF_VBLANK_START || a == OFF_VBLANK_STOP) vdcrWriteMask = 8'hff;
		else if (a == OFF_OUTPUT_FORMAT || a == OFF_SHARED_PIN) vdcrWriteMask = 8'h7f;
		else if (a == OFF_LUMA_TRAP || a == OFF_CROP_STOP_LO) vdcrWriteMask = 8'h03;
		else if (a == OFF_CROP_START_LO) vdcrWriteMask = 8'h07;
		else if (a == OFF_GENLOCK) vdcrWriteMask = 8'h05;
		else if (a == OFF_CHROMA_ONE) vdcrWriteMask = 8'h1f;
		else vdcrWriteMask = 8'h00;
	endfunction
	function automatic logic [7:0] vdcrResetValue(input logic [7:0] a);
		if (a == OFF_BRIGHTNESS || a == OFF_SATURATION || a == OFF_CONTRAST) vdcrResetValue = 8'h80;
		else if (a == OFF_OUTPUT_FORMAT) vdcrResetValue = 8'h47;
		else if (a == OFF_SHARED_PIN) vdcrResetValue = 8'h08;
		else if (a == OFF_GENLOCK) vdcrResetValue = 8'h05;
		else if (a == OFF_CHROMA_ONE) vdcrResetValue = 8'h0c;
		else vdcrResetValue = 8'h00;
	endfunction
	function automatic logic [REG_SLOTS-1:0][7:0] vdcrResetTable();
		for (int i = 0; i < REG_SLOTS; i++) begin
			vdcrResetTable[i] = vdcrResetValue(8'(i));
		end
	endfunction
	localparam logic [REG_SLOTS-1:0][7:0] RESET_REGS = vdcrResetTable();
endpackage
`default_nettype wire

//--- verilog/vdcr_i2c_slave.sv
`default_nettype none
module vdcr_i2c_slave (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	input  wire logic [7:0] rdData,
	output logic [7:0]      regAddr,
	output logic [7:0]      wrData,
	output logic            wrStrobe
);
	import vdcr_pkg::*;

	typedef struct packed {
		logic [1:0]      sclSync;
		logic [1:0]      sdaSync;
		logic            sclPrev;
		logic            sdaPrev;
		vdcr_i2c_state_t state;
		logic [3:0]      bitCnt;
		logic [7:0]      shift;
		logic [7:0]      pointer;
		logic            readMode;
		logic            ackSeen;
		logic            sdaOe;
		logic            wrStrobe;
	} vdcr_i2c_t;

	vdcr_i2c_t r;
	vdcr_i2c_t n;
	logic      sclRise;
	logic      sclFall;
	logic      startCond;
	logic      stopCond;

	assign sclRise   = r.sclSync[1] & ~r.sclPrev;
	assign sclFall   = ~r.sclSync[1] & r.sclPrev;
	assign startCond = r.sclSync[1] & r.sclPrev & r.sdaPrev & ~r.sdaSync[1];
	assign stopCond  = r.sclSync[1] & r.sclPrev & ~r.sdaPrev & r.sdaSync[1];
	assign sdaOut    = 1'b0;
	assign sdaOe     = r.sdaOe;
	assign regAddr   = r.pointer;
	assign wrData    = r.shift;
	assign wrStrobe  = r.wrStrobe;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = r;
		n.sclSync = {r.sclSync[0], sclIn};
		n.sdaSync = {r.sdaSync[0], sdaIn};
		n.sclPrev = r.sclSync[1];
		n.sdaPrev = r.sdaSync[1];
		n.wrStrobe = 1'b0;
		if (startCond) begin
			n.state = I2C_ADDR;
			n.bitCnt = 4'h0;
			n.sdaOe = 1'b0;
		end else if (stopCond) begin
			n.state = I2C_IDLE;
			n.sdaOe = 1'b0;
		end else begin
			case (r.state)
				I2C_ADDR, I2C_SUBADDR, I2C_WDATA: begin
					if (sclRise) begin
						n.shift = {r.shift[6:0], r.sdaSync[1]};
						n.bitCnt = r.bitCnt + 4'h1;
					end else if (sclFall && r.bitCnt == BITS_PER_BYTE) begin
						n.bitCnt = 4'h0;
						n.sdaOe = 1'b1;
						if (r.state == I2C_ADDR) begin
							if (r.shift[7:1] == DEV_ADDR) begin
								n.state = I2C_ACK_ADDR;
								n.readMode = r.shift[0];
							end else begin
								n.state = I2C_IDLE;
								n.sdaOe = 1'b0;
							end
						end else if (r.state == I2C_SUBADDR) begin
							n.state = I2C_ACK_SUB;
							n.pointer = r.shift;
						end else begin
							n.state = I2C_ACK_WR;
							n.wrStrobe = 1'b1;
						end
					end
				end
				I2C_ACK_ADDR: begin
					if (sclFall && r.readMode) begin
						n.state = I2C_RDATA;
						n.shift = rdData;
						n.sdaOe = ~rdData[7];
					end else if (sclFall) begin
						n.state = I2C_SUBADDR;
						n.sdaOe = 1'b0;
					end
				end
				I2C_ACK_SUB, I2C_ACK_WR: begin
					if (sclFall) begin
						n.state = I2C_WDATA;
						n.sdaOe = 1'b0;
						if (r.state == I2C_ACK_WR) n.pointer = r.pointer + 8'h01;
					end
				end
				I2C_RDATA: begin
					if (sclFall && r.bitCnt == LAST_BIT) begin
						n.state = I2C_RACK;
						n.sdaOe = 1'b0;
						n.bitCnt = 4'h0;
						n.pointer = r.pointer + 8'h01;
					end else if (sclFall) begin
						n.shift = {r.shift[6:0], 1'b0};
						n.sdaOe = ~r.shift[6];
						n.bitCnt = r.bitCnt + 4'h1;
					end
				end
				I2C_RACK: begin
					if (sclRise) begin
						n.ackSeen = ~r.sdaSync[1];
					end else if (sclFall && r.ackSeen) begin
						n.state = I2C_RDATA;
						n.shift = rdData;
						n.sdaOe = ~rdData[7];
					end else if (sclFall) begin
						n.state = I2C_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '{sclSync: 2'b11, sdaSync: 2'b11, sclPrev: 1'b1, sdaPrev: 1'b1, state: I2C_IDLE, default: '0};
		end else begin
			r <= n;
		end
	end
endmodule
`default_nettype wire

//--- verilog/vdcr_control_regs.sv
`default_nettype none
// Summary of operation
// RQ1: filter bit picks comb or chroma trap
// RQ2: peaking gain codes 0, 0.5, 1, 2
// RQ3: brightness unsigned byte, reset 128
// RQ4: saturation and contrast unsigned, reset 128
// RQ5: hue signed phase byte, reset zero
// RQ6: range bit picks standard or extended clipping
// RQ7: chroma coded offset binary or two's complement
// RQ8: bypass selects normal, decimated or raw data
// RQ9: format selects discrete or embedded sync
// RQ10: trap select picks one of four notches
// RQ11: override bits put combined lock on pins
// RQ12: pin selects field parity/lock, vsync/pal flag
// RQ13: request pin: interrupt, or general/vertical blank
// RQ14: clock pin: sample clock or pixel clock
// RQ15: crop position applies on low byte write
// RQ16: crop positions ten-bit signed, reset zero
// RQ17: active flag optionally suppressed in blanking
// RQ18: host keeps active pixel count even
// RQ19: oscillator lsb force and lock/rtc output select
// RQ20: blank edges shift later or earlier by lines
// RQ21: blank window drives flag and luma bypass
// RQ22: pll reset self-clears, marked next line
// RQ23: chroma gain mode; comb enables reset set
// RQ24: reserved bits zero; glitch-free registered updates
module vdcr_control_regs (
	input  wire logic       sys_clk,
	input  wire logic       rst,

	// serial pins
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,

	// pixel sources
	input  wire logic [7:0] lumaIn,
	input  wire logic [7:0] chromaIn,
	input  wire logic [7:0] decimLumaIn,
	input  wire logic [7:0] decimChromaIn,
	input  wire logic [7:0] adcSampleIn,

	// line timing
	input  wire logic [9:0] lineNumber,
	input  wire logic       lineStart,
	input  wire logic [9:0] blankStartLine,
	input  wire logic [9:0] blankStopLine,

	// status inputs
	input  wire logic       activeVideoIn,
	input  wire logic       fieldParityIn,
	input  wire logic       subcarrierLockIn,
	input  wire logic       realTimeControlIn,
	input  wire logic       vsyncIn,
	input  wire logic       palLineFlagIn,
	input  wire logic       horizontalLock,
	input  wire logic       verticalLock,
	input  wire logic       interruptRequestIn,
	input  wire logic       generalPurposeIn,
	input  wire logic       vblankPinSelect,
	input  wire logic       lumaBypassVblankEnable,

	// pixel out
	output logic [7:0]      lumaOut,
	output logic [7:0]      chromaOut,

	// shared pins
	output logic            pin23Out,
	output logic            pin24Out,
	output logic            pin27Out,
	output logic            clockPinPixel,

	// register fields
	output logic            lumaChromaTrap,
	output logic [1:0]      peakingGain,
	output logic [7:0]      brightness,
	output logic [7:0]      saturation,
	output logic [7:0]      hue,
	output logic [7:0]      contrast,
	output logic [1:0]      trapSelect,

	// format decode
	output logic            syncEmbedded,
	output logic            formatReserved,

	// crop and blank
	output logic [9:0]      activeStartPixel,
	output logic [9:0]      activeStopPixel,
	output logic            activeVideoFlag,
	output logic            verticalBlankFlag,
	output logic            lumaBypassActive,

	// genlock and chroma
	output logic            oscillatorLsbForce,
	output logic            colourPllReset,
	output logic            subcarrierPhaseResetFlag,
	output logic [1:0]      autoChromaGain,
	output logic            adaptiveCombEnable,
	output logic            combEnable
);
	import vdcr_pkg::*;

	typedef struct packed {
		// register file, one byte per offset
		logic [REG_SLOTS-1:0][7:0] regs;

		logic [9:0]                startPixel;
		logic [9:0]                stopPixel;

		logic [7:0]                lumaOut;
		logic [7:0]                chromaOut;
		logic                      bypassPhase;

		logic                      pin23;
		logic                      pin24;
		logic                      pin27;

		logic                      vblank;
		logic                      active_video_flag;
		logic                      lumaBypass;

		logic                      phaseResetPending;
		logic                      phaseResetFlag;
	} vdcr_regs_t;

	vdcr_regs_t  r;
	vdcr_regs_t  n;

	logic [7:0]  regAddr;
	logic [7:0]  wrData;
	logic        wrStrobe;
	logic [7:0]  rdData;

	logic [7:0]  pinCfg;
	logic        lockBoth;
	logic        carrierOrRtc;
	logic        inBlank;
	logic        pllResetWrite;

	logic signed [11:0] blankStartEdge;
	logic signed [11:0] blankStopEdge;
	logic signed [11:0] lineSigned;

	logic [7:0]  chromaOffset;
	logic [7:0]  chromaClipped;
	logic [7:0]  clipLow;
	logic [7:0]  lumaHigh;
	logic [7:0]  chromaHigh;

	////////////////////////////////////////////////////////////////////////////////
	// serial control port
	vdcr_i2c_slave u_serial (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.sclIn    (sclIn),
		.sdaIn    (sdaIn),
		.sdaOut   (sdaOut),
		.sdaOe    (sdaOe),
		.rdData   (rdData),
		.regAddr  (regAddr),
		.wrData   (wrData),
		.wrStrobe (wrStrobe)
	);

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	// saturate a code into lo..hi
	function automatic logic [7:0] clip8(input logic [7:0] x, input logic [7:0] lo, input logic [7:0] hi);
		if (x < lo) begin
			clip8 = lo;
		end else if (x > hi) begin
			clip8 = hi;
		end else begin
			clip8 = x;
		end
	endfunction

	// positive codes move the edge later, codes 0x81 to 0xff move it earlier
	function automatic logic signed [11:0] shiftEdge(input logic [9:0] std, input logic [7:0] code);
		logic [7:0] earlier;
		earlier = (code == EARLIEST_CODE) ? EARLY_MAX : {1'b0, code[6:0]};
		if (code[7]) begin
			shiftEdge = $signed({2'b00, std}) - $signed({4'h0, earlier});
		end else begin
			shiftEdge = $signed({2'b00, std}) + $signed({5'h00, code[6:0]});
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// readback: reserved bits and the self-clearing pll bit read zero
	always_comb begin
		rdData = 8'h00;
		if (regAddr[7:5] == 3'b000) begin
			rdData = r.regs[regAddr[4:0]] & vdcrWriteMask(regAddr); // see RQ24
			if (regAddr == OFF_CHROMA_ONE) begin
				rdData[PLL_RESET_BIT] = 1'b0; // see RQ22
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared terms
	assign pinCfg         = r.regs[OFF_SHARED_PIN[4:0]];
	assign lockBoth       = horizontalLock & verticalLock; // see RQ11
	assign carrierOrRtc   = r.regs[OFF_GENLOCK[4:0]][RTC_SEL_BIT] ? realTimeControlIn
	                        : (subcarrierLockIn | r.phaseResetFlag); // see RQ19 see RQ22
	assign pllResetWrite  = wrStrobe && regAddr == OFF_CHROMA_ONE && wrData[PLL_RESET_BIT];

	assign blankStartEdge = shiftEdge(blankStartLine, r.regs[OFF_VBLANK_START[4:0]]); // see RQ20
	assign blankStopEdge  = shiftEdge(blankStopLine, r.regs[OFF_VBLANK_STOP[4:0]]); // see RQ20
	assign lineSigned     = $signed({2'b00, lineNumber});
	assign inBlank        = (lineSigned >= blankStartEdge) && (lineSigned < blankStopEdge); // see RQ21

	assign clipLow        = r.regs[OFF_OUTPUT_FORMAT[4:0]][RANGE_BIT] ? CODE_MIN_EXT : LUMA_MIN_STD; // see RQ6
	assign lumaHigh       = r.regs[OFF_OUTPUT_FORMAT[4:0]][RANGE_BIT] ? CODE_MAX_EXT : LUMA_MAX_STD; // see RQ6
	assign chromaHigh     = r.regs[OFF_OUTPUT_FORMAT[4:0]][RANGE_BIT] ? CODE_MAX_EXT : CHROMA_MAX_STD; // see RQ6
	// chroma is clipped in offset form, then recoded to two's complement when the format bit is set
	assign chromaOffset   = {~chromaIn[7], chromaIn[6:0]};
	assign chromaClipped  = clip8(chromaOffset, clipLow, chromaHigh);

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		n = r;
		n.regs[OFF_CHROMA_ONE[4:0]][PLL_RESET_BIT] = 1'b0; // see RQ22

		for (int i = 0; i < REG_SLOTS; i++) begin
			if (wrStrobe && regAddr == 8'(i)) begin
				n.regs[i] = wrData & vdcrWriteMask(8'(i)); // see RQ24
			end
		end

		// crop positions move only when the low byte lands
		if (wrStrobe && regAddr == OFF_CROP_START_LO) begin
			n.startPixel = {r.regs[OFF_CROP_START_HI[4:0]], wrData[1:0]}; // see RQ15 see RQ16
		end

		if (wrStrobe && regAddr == OFF_CROP_STOP_LO) begin
			n.stopPixel = {r.regs[OFF_CROP_STOP_HI[4:0]], wrData[1:0]}; // see RQ15 see RQ16
		end

		// phase reset is marked for the whole line after the write
		if (lineStart) begin
			n.phaseResetFlag = r.phaseResetPending; // see RQ22
			n.phaseResetPending = 1'b0;
		end
		if (pllResetWrite) begin
			n.phaseResetPending = 1'b1; // see RQ22
		end

		// blank window and the flags it gates
		n.vblank = inBlank; // see RQ21
		n.lumaBypass = inBlank & lumaBypassVblankEnable; // see RQ21
		n.active_video_flag = activeVideoIn & ~(r.regs[OFF_CROP_START_LO[4:0]][ACTIVE_VIDEO_FLAG_SUPPRESS_BIT] & inBlank); // see RQ17

		// shared pins
		if (pinCfg[PIN23_SEL_BIT]) begin
			n.pin23 = carrierOrRtc; // see RQ12
		end else if (pinCfg[PIN23_LOCK_BIT]) begin
			n.pin23 = lockBoth; // see RQ11
		end else begin
			n.pin23 = fieldParityIn; // see RQ12
		end
		if (pinCfg[PIN24_SEL_BIT]) begin
			n.pin24 = pinCfg[PALFLAG_LOCK_BIT] ? lockBoth : palLineFlagIn; // see RQ11 see RQ12
		end else begin
			n.pin24 = pinCfg[VSYNC_LOCK_BIT] ? lockBoth : vsyncIn; // see RQ11 see RQ12
		end
		if (pinCfg[PIN27_SEL_BIT]) begin
			n.pin27 = vblankPinSelect ? inBlank : generalPurposeIn; // see RQ13
		end else begin
			n.pin27 = interruptRequestIn; // see RQ13
		end

		// pixel datapath
		n.bypassPhase = 1'b0;
		case (r.regs[OFF_OUTPUT_FORMAT[4:0]][BYPASS_LSB +: 2])
			BYPASS_DECIM: begin
				n.bypassPhase = ~r.bypassPhase; // see RQ8
				n.lumaOut = r.bypassPhase ? decimChromaIn : decimLumaIn; // see RQ8
				n.chromaOut = CHROMA_ZERO;
			end
			BYPASS_RAW: begin
				n.lumaOut = adcSampleIn; // see RQ8
				n.chromaOut = CHROMA_ZERO;
			end
			default: begin
				n.lumaOut = clip8(lumaIn, clipLow, lumaHigh); // see RQ6
				if (r.regs[OFF_OUTPUT_FORMAT[4:0]][CHROMA_FMT_BIT]) begin
					n.chromaOut = {~chromaClipped[7], chromaClipped[6:0]}; // see RQ7
				end else begin
					n.chromaOut = chromaClipped; // see RQ7
				end
			end
		endcase
	end

	// one register stage holds all state except the serial slave's, which u_serial registers itself
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '{regs: RESET_REGS, default: '0};
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs from flip-flops; syncEmbedded and formatReserved are decoded from register bits
	assign lumaOut                  = r.lumaOut;
	assign chromaOut                = r.chromaOut;

	assign pin23Out                 = r.pin23;
	assign pin24Out                 = r.pin24;
	assign pin27Out                 = r.pin27;
	assign clockPinPixel            = pinCfg[CLOCK_SEL_BIT]; // see RQ14

	assign lumaChromaTrap           = r.regs[OFF_LUMA_PROC_TWO[4:0]][LUMA_FILTER_BIT]; // see RQ1
	assign peakingGain              = r.regs[OFF_LUMA_PROC_TWO[4:0]][PEAK_LSB +: 2]; // see RQ2

	assign brightness               = r.regs[OFF_BRIGHTNESS[4:0]]; // see RQ3
	assign saturation               = r.regs[OFF_SATURATION[4:0]]; // see RQ4
	assign hue                      = r.regs[OFF_HUE[4:0]]; // see RQ5
	assign contrast                 = r.regs[OFF_CONTRAST[4:0]]; // see RQ4

	assign trapSelect               = r.regs[OFF_LUMA_TRAP[4:0]][1:0]; // see RQ10
	assign syncEmbedded             = r.regs[OFF_OUTPUT_FORMAT[4:0]][2:0] == FORMAT_EMBEDDED; // see RQ9
	assign formatReserved           = (r.regs[OFF_OUTPUT_FORMAT[4:0]][2:0] != FORMAT_EMBEDDED)
	                                  && (r.regs[OFF_OUTPUT_FORMAT[4:0]][2:0] != FORMAT_DISCRETE); // see RQ9

	assign activeStartPixel         = r.startPixel;
	assign activeStopPixel          = r.stopPixel;
	assign activeVideoFlag          = r.active_video_flag;
	assign verticalBlankFlag        = r.vblank;
	assign lumaBypassActive         = r.lumaBypass;

	assign oscillatorLsbForce       = r.regs[OFF_GENLOCK[4:0]][OSC_LSB_BIT]; // see RQ19
	assign colourPllReset           = r.regs[OFF_CHROMA_ONE[4:0]][PLL_RESET_BIT]; // see RQ22
	assign subcarrierPhaseResetFlag = r.phaseResetFlag;
	assign autoChromaGain           = r.regs[OFF_CHROMA_ONE[4:0]][1:0]; // see RQ23
	assign adaptiveCombEnable       = r.regs[OFF_CHROMA_ONE[4:0]][ADAPTIVE_BIT]; // see RQ23
	assign combEnable               = r.regs[OFF_CHROMA_ONE[4:0]][COMB_BIT]; // see RQ23
endmodule
`default_nettype wire

//--- sim/vdcr_monitor.sv
`default_nettype none
module vdcr_monitor (
	input wire logic sys_clk, rst, lineStart, activeVideoIn, fieldParityIn, subcarrierLockIn, realTimeControlIn,
	input wire logic vsyncIn, palLineFlagIn, horizontalLock, verticalLock, interruptRequestIn, generalPurposeIn,
	input wire logic lumaBypassVblankEnable, pin23Out, pin24Out, pin27Out, syncEmbedded, formatReserved,
	input wire logic activeVideoFlag, verticalBlankFlag, lumaBypassActive, colourPllReset, subcarrierPhaseResetFlag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_pll_pulse: assert property (colourPllReset |=> !colourPllReset)
		else $error("pll reset pulse too long");
	a_phase_rise: assert property ($rose(subcarrierPhaseResetFlag) |-> $past(lineStart))
		else $error("phase flag set off a line start");
	a_phase_fall: assert property ($fell(subcarrierPhaseResetFlag) |-> $past(lineStart))
		else $error("phase flag cleared off a line start");
	a_bypass_window: assert property (lumaBypassActive |-> $past(lumaBypassVblankEnable) && verticalBlankFlag)
		else $error("luma bypass outside blank window");
	a_active_source: assert property (activeVideoFlag |-> $past(activeVideoIn))
		else $error("active flag without input");
	a_pin23_source: assert property (pin23Out |-> $past(fieldParityIn || subcarrierLockIn || realTimeControlIn
		|| horizontalLock && verticalLock) || subcarrierPhaseResetFlag || $past(subcarrierPhaseResetFlag))
		else $error("pin23 high without source");
	a_pin24_source: assert property (pin24Out |-> $past(vsyncIn || palLineFlagIn || horizontalLock && verticalLock))
		else $error("pin24 high without source");
	a_pin27_source: assert property (pin27Out |-> $past(interruptRequestIn || generalPurposeIn)
		|| verticalBlankFlag || $past(verticalBlankFlag))
		else $error("pin27 high without source");
	a_format_decode: assert property (syncEmbedded |-> !formatReserved)
		else $error("format both embedded and reserved");
endmodule
bind vdcr_control_regs vdcr_monitor i_mon (.*);
`default_nettype wire

//--- sim/tb_video_decoder_control_regs.sv
`default_nettype none
module tb_video_decoder_control_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import vdcr_pkg::*;
	logic sys_clk = 0, rst = 1, sclIn = 1, sdaM = 1, sdaOut, sdaOe, pulse = 0;
	wire sdaIn = sdaM & ~sdaOe;
	logic [7:0] lumaIn = 8'h20, chromaIn = 8'h05, decimLumaIn = 8'h11, decimChromaIn = 8'h22, adcSampleIn = 8'h33;
	logic [9:0] lineNumber = 10'h000, blankStartLine = 10'h014, blankStopLine = 10'h01e;
	logic lineStart = 0, activeVideoIn = 1, fieldParityIn = 0, subcarrierLockIn = 0, realTimeControlIn = 0;
	logic vsyncIn = 0, palLineFlagIn = 0, horizontalLock = 0, verticalLock = 0, interruptRequestIn = 1;
	logic generalPurposeIn = 0, vblankPinSelect = 0, lumaBypassVblankEnable = 1;
	logic [7:0] lumaOut, chromaOut, brightness, saturation, hue, contrast, rd;
	logic [1:0] peakingGain, trapSelect, autoChromaGain;
	logic [9:0] activeStartPixel, activeStopPixel;
	logic pin23Out, pin24Out, pin27Out, clockPinPixel, lumaChromaTrap, syncEmbedded, formatReserved;
	logic activeVideoFlag, verticalBlankFlag, lumaBypassActive, oscillatorLsbForce, colourPllReset;
	logic subcarrierPhaseResetFlag, adaptiveCombEnable, combEnable;
	int num_errors = 0, check_count = 0;
	localparam logic [15:0] RST_TAB [11] = '{16'h0800, 16'h0980, 16'h0a80, 16'h0b00, 16'h0c80, 16'h0d47,
		16'h0e00, 16'h0f08, 16'h1000, 16'h1505, 16'h1a0c};
	vdcr_control_regs i_dut (.*);
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (colourPllReset) pulse <= 1'b1;
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(string name, logic [9:0] exp, logic [9:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic bitx(logic b, output logic s);
		sdaM = b;
		tick(10);
		sclIn = 1;
		tick(10);
		s = sdaIn;
		sclIn = 0;
	endtask
	// start and repeated start alike
	task automatic start();
		sdaM = 1;
		tick(10);
		sclIn = 1;
		tick(10);
		sdaM = 0;
		tick(10);
		sclIn = 0;
	endtask
	task automatic stop();
		sdaM = 0;
		tick(10);
		sclIn = 1;
		tick(10);
		sdaM = 1;
		tick(10);
	endtask
	task automatic sendb(logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(v[i], s);
		bitx(1'b1, s);
		chk("ack", 10'h000, s);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		start();
		sendb({DEV_ADDR, 1'b0});
		sendb(a);
		sendb(d);
		stop();
		tick(4);
	endtask
	task automatic rchk(logic [7:0] a, logic [7:0] e);
		logic s;
		start();
		sendb({DEV_ADDR, 1'b0});
		sendb(a);
		start();
		sendb({DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) bitx(1'b1, rd[i]);
		bitx(1'b1, s);
		stop();
		chk($sformatf("reg %h", a), e, rd);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		tick(16);
		rst = 0;
		tick(4);
		foreach (RST_TAB[i]) rchk(RST_TAB[i][15:8], RST_TAB[i][7:0]);
		chk("lsb force", 1, oscillatorLsbForce);
		chk("comb", 1, combEnable & adaptiveCombEnable);
		chk("embedded", 1, syncEmbedded);
		chk("levels", 8'h80, brightness & saturation & contrast);
		wr(OFF_LUMA_PROC_TWO, 8'hff);
		rchk(OFF_LUMA_PROC_TWO, 8'h4c);
		chk("trap", 1, lumaChromaTrap);
		chk("peaking", 3, peakingGain);
		wr(8'h10, 8'hff);
		rchk(8'h10, 8'h00);
		wr(OFF_LUMA_TRAP, 8'h02);
		chk("notch", 2, trapSelect);
		wr(OFF_HUE, 8'h80);
		chk("hue", 8'h80, hue);
		wr(OFF_OUTPUT_FORMAT, 8'h01);
		chk("reserved fmt", 1, {syncEmbedded, formatReserved});
		lumaIn = 8'h05;
		chromaIn = 8'h7f;
		tick(2);
		chk("luma std", LUMA_MIN_STD, lumaOut);
		chk("chroma std", CHROMA_MAX_STD, chromaOut);
		wr(OFF_OUTPUT_FORMAT, 8'h67);
		chk("luma ext", 8'h05, lumaOut);
		chk("chroma ext", 8'h7e, chromaOut);
		wr(OFF_OUTPUT_FORMAT, 8'h17);
		chk("raw", 8'h33, lumaOut);
		wr(OFF_OUTPUT_FORMAT, 8'h0f);
		rd = lumaOut;
		tick(1);
		chk("decim", 8'h33, lumaOut ^ rd);
		chk("bypass chroma", CHROMA_ZERO, chromaOut);
		wr(OFF_CROP_START_HI, 8'h80);
		chk("start", 10'h000, activeStartPixel);
		wr(OFF_CROP_START_LO, 8'h07);
		chk("start", 10'h203, activeStartPixel);
		wr(OFF_CROP_STOP_HI, 8'h7f);
		wr(OFF_CROP_STOP_LO, 8'h03);
		chk("stop", 10'h1ff, activeStopPixel);
		wr(OFF_SHARED_PIN, 8'h40);
		horizontalLock = 1;
		fieldParityIn = 1;
		vsyncIn = 1;
		tick(2);
		chk("pins", 3'b011, {pin23Out, pin24Out, pin27Out});
		verticalLock = 1;
		tick(2);
		chk("pin23", 1, pin23Out);
		wr(OFF_SHARED_PIN, 8'h03);
		chk("clock pin", 1, clockPinPixel);
		chk("pin27", 0, pin27Out);
		wr(OFF_CHROMA_ONE, 8'h1e);
		rchk(OFF_CHROMA_ONE, 8'h0e);
		chk("gain", 2, autoChromaGain);
		chk("pll pulse", 1, pulse);
		lineStart = 1;
		tick(1);
		lineStart = 0;
		tick(2);
		chk("phase flag", 1, subcarrierPhaseResetFlag);
		lineStart = 1;
		tick(1);
		lineStart = 0;
		tick(2);
		chk("phase flag", 0, subcarrierPhaseResetFlag);
		wr(OFF_VBLANK_START, 8'h02);
		wr(OFF_VBLANK_STOP, 8'h81);
		for (int n = 21; n < 31; n++) begin
			lineNumber = 10'(n);
			tick(2);
			chk("blank", (n >= 22 && n < 29) ? 3'b110 : 3'b001,
				{verticalBlankFlag, lumaBypassActive, activeVideoFlag});
		end
		end_of_test();
	end
	initial begin
		tick(60000);
		num_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
